// >>> bench/test_bit_and_branch_decoder.sv
// Self-checking bench for the bit and branch decoder, driven straight at its ports.
// Assumes bbd_pkg is compiled first; a queue of notes is matched on every o_done.
`timescale 1ns/1ps
module test_bit_and_branch_decoder;
    import bbd_pkg::*;
    typedef struct packed {logic [15:0] pc; logic [1:0] len; logic cy; logic ck;} bbd_exp_t;
    logic i_sys_clk = 0, i_reset_n = 0, i_start = 0, i_bit_value = 0;
    logic [15:0] i_pc = 0, i_data_pointer_16 = 0, i_stack_pc = 0;
    logic [7:0] i_opcode = 0, i_byte2 = 0, i_byte3 = 0, i_acc = 0, i_operand = 0;
    logic [7:0] i_indirect_data = 0;
    logic [1:0] i_bank = 0;
    logic o_busy, o_done, o_illegal, o_carry, o_bit_we, o_bit_wdata, o_direct_is_sfr;
    logic o_byte_we, o_push_pc, o_pop_pc, o_release_prio;
    logic [15:0] o_pc;
    logic [7:0] o_bit_addr, o_direct_addr, o_byte_wdata;
    logic [4:0] o_reg_addr, o_indirect_ptr_addr;
    logic [1:0] o_len;
    bbd_exp_t q[$];
    bbd_exp_t e;
    int n_fail = 0, checked = 0, k, j;
    logic [31:0] seed = 32'hf4c3;
    logic [7:0] b, r, x, y, op;
    logic cy = 0, ck = 1, t;
    logic [7:0] ops[4];

    bbd_decoder u_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_start(i_start),
        .i_pc(i_pc), .i_opcode(i_opcode), .i_byte2(i_byte2), .i_byte3(i_byte3), .i_acc(i_acc),
        .i_data_pointer_16(i_data_pointer_16), .i_bank(i_bank), .i_bit_value(i_bit_value),
        .i_operand(i_operand), .i_indirect_data(i_indirect_data), .i_stack_pc(i_stack_pc),
        .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_pc(o_pc),
        .o_carry(o_carry), .o_bit_addr(o_bit_addr), .o_bit_we(o_bit_we),
        .o_bit_wdata(o_bit_wdata), .o_direct_addr(o_direct_addr),
        .o_direct_is_sfr(o_direct_is_sfr), .o_reg_addr(o_reg_addr),
        .o_indirect_ptr_addr(o_indirect_ptr_addr), .o_byte_we(o_byte_we),
        .o_byte_wdata(o_byte_wdata), .o_push_pc(o_push_pc), .o_pop_pc(o_pop_pc),
        .o_release_prio(o_release_prio), .o_len(o_len));

    always #25 i_sys_clk = ~i_sys_clk;

    function logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction

    function automatic logic [15:0] br(input logic [15:0] nx, input logic [7:0] rl, input logic tk);
        return tk ? nx + {{8{rl[7]}}, rl} : nx;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic rand_in();
        i_pc = {rnd(), rnd()};
        i_acc = rnd();
        i_data_pointer_16 = {rnd(), rnd()};
        i_bank = 2'(rnd());
        i_bit_value = 1'(rnd());
        i_operand = rnd();
        i_indirect_data = rnd();
        i_stack_pc = {rnd(), rnd()};
    endtask

    task automatic issue(input logic [7:0] oc, b2, b3, input int cyc, input logic [1:0] ln,
                         input logic [15:0] epc, input logic [1:0] bw,
                         input logic [4:0] fx = 5'h00, input logic [7:0] bd = 8'h00);
        int n;
        i_opcode = oc;
        i_byte2 = b2;
        i_byte3 = b3;
        i_start = 1;
        q.push_back('{epc, ln, cy, ck});
        #5;
        check(o_direct_is_sfr, b2 > 8'h7F);
        check(o_direct_addr, b2);
        if (oc[3] && (oc[7:4] == HI_COMPARE_BRANCH_UNEQUAL || oc[7:4] == HI_DECREMENT_BRANCH_NONZERO))
            check(o_reg_addr, {i_bank, oc[2:0]});
        if (oc == 8'hB6 || oc == 8'hB7)
            check(o_indirect_ptr_addr, {i_bank, 2'b00, oc[0]});
        @(posedge i_sys_clk);
        #1;
        check({o_bit_we, o_bit_we & o_bit_wdata}, bw);
        check({o_illegal, o_byte_we, o_push_pc, o_pop_pc, o_release_prio}, fx);
        if (fx[3]) check(o_byte_wdata, bd);
        check(o_bit_addr, b2);
        check(o_busy, cyc == 2);
        n = 1;
        while (o_done !== 1'b1 && n < 5) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        check(n, cyc);
    endtask

    always @(posedge i_sys_clk) begin
        if (o_done === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : '1;
            check({o_pc, o_len, o_carry & e.ck}, {e.pc, e.len, e.cy & e.ck});
        end
    end

    initial begin
        #150000;
        n_fail++;
        results();
    end

    initial begin
        repeat (3) @(posedge i_sys_clk);
        #1 i_reset_n = 1;
        rand_in(); cy = 0; issue(OP_CLRC, 0, 0, 1, LEN_1, i_pc + 16'h0001, 0);
        rand_in(); cy = 1; issue(OP_SETBC, 0, 0, 1, LEN_1, i_pc + 16'h0001, 0);
        rand_in(); cy = ~cy; issue(OP_CPLC, 0, 0, 1, LEN_1, i_pc + 16'h0001, 0);
        rand_in(); issue(OP_CLRB, rnd(), 0, 1, LEN_2, i_pc + 16'h0002, 2'b10);
        rand_in(); issue(OP_SETBB, rnd(), 0, 1, LEN_2, i_pc + 16'h0002, 2'b11);
        rand_in(); issue(OP_CPLB, rnd(), 0, 1, LEN_2, i_pc + 16'h0002, {1'b1, ~i_bit_value});
        ops = '{OP_ANC, OP_ANNC, OP_ORC, OP_ORNC};
        for (k = 0; k < 16; k++) begin
            rand_in(); j = k % 4;
            t = (j[0]) ? ~i_bit_value : i_bit_value;
            cy = (j < 2) ? (cy & t) : (cy | t);
            issue(ops[j], rnd(), 0, 2, LEN_2, i_pc + 16'h0002, 0);
        end
        rand_in(); cy = i_bit_value; issue(OP_MOVCB, rnd(), 0, 1, LEN_2, i_pc + 16'h0002, 0);
        rand_in(); issue(OP_MOVBC, rnd(), 0, 2, LEN_2, i_pc + 16'h0002, {1'b1, cy});
        rand_in(); b = rnd(); r = rnd(); issue(OP_LONG_JUMP, b, r, 2, LEN_3, {b, r}, 0);
        rand_in(); b = rnd(); r = rnd();
        issue(OP_LONG_CALL, b, r, 2, LEN_3, {b, r}, 0, 5'b00100);
        for (k = 0; k < 16; k++) begin
            rand_in(); i_pc = {rnd(), 8'hFF} | 16'h0700; b = rnd();
            x = 8'(k);
            issue({x[3:0], LO_PAGE}, b, 0, 2, LEN_2, {i_pc[15:11] + 5'h01, x[3:1], b}, 0,
                  {2'b00, x[0], 2'b00});
        end
        for (k = 0; k < 3; k++) begin
            rand_in(); r = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : rnd();
            issue(OP_SHORT_JUMP, r, 0, 2, LEN_2, br(i_pc + 16'h0002, r, 1), 0);
        end
        rand_in(); issue(OP_JMPI, 0, 0, 2, LEN_1, {8'h00, i_acc} + i_data_pointer_16, 0);
        ops = '{OP_JZ, OP_JNZ, OP_JC, OP_JNC};
        for (k = 0; k < 16; k++) begin
            rand_in(); j = k % 4; r = rnd();
            if (k[2]) i_acc = 0;
            t = (j == 0) ? (i_acc == 0) : (j == 1) ? (i_acc != 0) : (j == 2) ? cy : ~cy;
            issue(ops[j], r, 0, 2, LEN_2, br(i_pc + 16'h0002, r, t), 0);
            rand_in(); cy = ~cy; issue(OP_CPLC, 0, 0, 1, LEN_1, i_pc + 16'h0001, 0);
        end
        ops = '{OP_JB, OP_JNB, OP_JBC, OP_JB};
        for (k = 0; k < 12; k++) begin
            rand_in(); j = k % 3; r = rnd();
            t = (j == 1) ? ~i_bit_value : i_bit_value;
            issue(ops[j], rnd(), r, 2, LEN_3, br(i_pc + 16'h0003, r, t),
                  {(j == 2) && i_bit_value, 1'b0});
        end
        ck = 0;
        for (k = 0; k < 16; k++) begin
            rand_in(); j = k % 4; b = rnd(); r = rnd();
            if (k[2]) begin
                i_operand = i_acc; i_indirect_data = i_acc; b = i_acc;
            end
            op = (j == 0) ? OP_CJAI : (j == 1) ? OP_CJAD : (j == 2) ? {5'b10111, r[2:0]}
                 : {7'b1011011, r[0]};
            x = (j < 2) ? i_acc : (j == 2) ? i_operand : i_indirect_data;
            y = (j == 1) ? i_operand : b;
            issue(op, b, r, 2, LEN_3, br(i_pc + 16'h0003, r, x !== y), 0);
        end
        ck = 1;
        rand_in(); cy = 0; issue(OP_CLRC, 0, 0, 1, LEN_1, i_pc + 16'h0001, 0);
        for (k = 0; k < 8; k++) begin
            rand_in(); r = rnd();
            if (k[1]) i_operand = 8'h01;
            y = i_operand - 8'h01;
            t = y != 8'h00;
            if (k[0])
                issue(OP_DJD, rnd(), r, 2, LEN_3, br(i_pc + 16'h0003, r, t), 0,
                      5'b01000, y);
            else
                issue({5'b11011, r[2:0]}, r, 0, 2, LEN_2, br(i_pc + 16'h0002, r, t), 0,
                      5'b01000, y);
        end
        rand_in(); issue(OP_NOP, 0, 0, 1, LEN_1, i_pc + 16'h0001, 0);
        rand_in(); issue(8'hA5, 0, 0, 1, LEN_1, i_pc + 16'h0001, 0, 5'b10000);
        rand_in(); issue(OP_RET, 0, 0, 2, LEN_1, i_stack_pc, 0, 5'b00010);
        rand_in(); issue(OP_INTERRUPT_EXIT, 0, 0, 2, LEN_1, i_stack_pc, 0, 5'b00011);
        i_start = 0;
        repeat (3) @(posedge i_sys_clk);
        check(q.size(), 0);
        results();
    end
endmodule

// >>> hdl/bbd_decoder.sv
// Execute unit for the boolean and program-control instructions.
// Assumes the core presents all instruction bytes and operand values with
// i_start, accepts write-backs in the cycle after i_start, and takes the new counter on o_done.
`timescale 1ns/1ps
module bbd_decoder (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_start,
    input  wire logic [15:0] i_pc,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_byte2,
    input  wire logic [7:0]  i_byte3,
    input  wire logic [7:0]  i_acc,
    input  wire logic [15:0] i_data_pointer_16,
    input  wire logic [1:0]  i_bank,
    input  wire logic        i_bit_value,
    input  wire logic [7:0]  i_operand,
    input  wire logic [7:0]  i_indirect_data,
    input  wire logic [15:0] i_stack_pc,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_illegal,
    output logic [15:0]      o_pc,
    output logic             o_carry,
    output logic [7:0]       o_bit_addr,
    output logic             o_bit_we,
    output logic             o_bit_wdata,
    output logic [7:0]       o_direct_addr,
    output logic             o_direct_is_sfr,
    output logic [4:0]       o_reg_addr,
    output logic [4:0]       o_indirect_ptr_addr,
    output logic             o_byte_we,
    output logic [7:0]       o_byte_wdata,
    output logic             o_push_pc,
    output logic             o_pop_pc,
    output logic             o_release_prio,
    output logic [1:0]       o_len
);
    import bbd_pkg::*;

    function automatic logic [15:0] rel_target(input logic [15:0] nxt, input logic [7:0] d);
        rel_target = nxt + {{8{d[7]}}, d};
    endfunction

    logic [1:0] len_w;
    logic [1:0] cyc_w;
    logic       known_w;

    bbd_len_table u_len (
        .i_opcode (i_opcode),
        .o_len    (len_w),
        .o_cycles (cyc_w),
        .o_known  (known_w)
    );

    bbd_state_t  state_r, state_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic        carry_r, carry_nxt;
    logic        done_r, done_nxt;
    logic        ill_r, ill_nxt;
    logic [7:0]  bit_addr_r, bit_addr_nxt;
    logic        bit_we_r, bit_we_nxt;
    logic        bit_wd_r, bit_wd_nxt;
    logic        byte_we_r, byte_we_nxt;
    logic [7:0]  byte_wd_r, byte_wd_nxt;
    logic        push_r, push_nxt;
    logic        pop_r, pop_nxt;
    logic        rel_r, rel_nxt;
    logic [1:0]  len_r, len_nxt;

    logic [15:0] next_pc;
    logic [7:0]  dec_val;
    logic        is_rr_compare_branch_unequal;
    logic        is_rr_decrement_branch_nonzero;

    // Operand addressing is purely combinational from the current opcode, bank and second byte.
    assign o_reg_addr          = {i_bank, i_opcode[2:0]};
    assign o_indirect_ptr_addr = {i_bank, 2'b00, i_opcode[0]};
    assign o_direct_addr       = i_byte2;
    assign o_direct_is_sfr     = (i_byte2 > DIRECT_RAM_TOP);
    assign o_busy              = (state_r != BBD_FETCH);

    always_comb begin
        next_pc      = i_pc + {14'h0000, len_w};
        dec_val      = i_operand - 8'h01;
        is_rr_compare_branch_unequal   = (i_opcode[7:4] == HI_COMPARE_BRANCH_UNEQUAL) && i_opcode[3];
        is_rr_decrement_branch_nonzero   = (i_opcode[7:4] == HI_DECREMENT_BRANCH_NONZERO) && i_opcode[3];
        state_nxt    = state_r;
        pc_nxt       = pc_r;
        carry_nxt    = carry_r;
        done_nxt     = 1'b0;
        ill_nxt      = 1'b0;
        bit_addr_nxt = bit_addr_r;
        bit_we_nxt   = 1'b0;
        bit_wd_nxt   = bit_wd_r;
        byte_we_nxt  = 1'b0;
        byte_wd_nxt  = byte_wd_r;
        push_nxt     = 1'b0;
        pop_nxt      = 1'b0;
        rel_nxt      = 1'b0;
        len_nxt      = len_r;
        case (state_r)
            BBD_FETCH: begin
                if (i_start) begin
                    len_nxt      = len_w;
                    pc_nxt       = next_pc;
                    bit_addr_nxt = i_byte2;
                    ill_nxt      = ~known_w;
                    if (i_opcode[3:0] == LO_PAGE) begin
                        pc_nxt   = {next_pc[15:11], i_opcode[7:5], i_byte2};
                        push_nxt = i_opcode[4];
                    end else if (is_rr_compare_branch_unequal) begin
                        if (i_operand != i_byte2)
                            pc_nxt = rel_target(next_pc, i_byte3);
                    end else if (is_rr_decrement_branch_nonzero) begin
                        byte_we_nxt = 1'b1;
                        byte_wd_nxt = dec_val;
                        if (dec_val != 8'h00)
                            pc_nxt = rel_target(next_pc, i_byte2);
                    end else begin
                        case (i_opcode)
                            OP_CLRC:   carry_nxt = 1'b0;
                            OP_SETBC:  carry_nxt = 1'b1;
                            OP_CPLC:   carry_nxt = ~carry_r;
                            OP_CLRB: begin
                                bit_we_nxt = 1'b1;
                                bit_wd_nxt = 1'b0;
                            end
                            OP_SETBB: begin
                                bit_we_nxt = 1'b1;
                                bit_wd_nxt = 1'b1;
                            end
                            OP_CPLB: begin
                                bit_we_nxt = 1'b1;
                                bit_wd_nxt = ~i_bit_value;
                            end
                            OP_MOVCB:  carry_nxt = i_bit_value;
                            OP_MOVBC: begin
                                bit_we_nxt = 1'b1;
                                bit_wd_nxt = carry_r;
                            end
                            OP_ANC:    carry_nxt = carry_r & i_bit_value;
                            OP_ANNC:   carry_nxt = carry_r & ~i_bit_value;
                            OP_ORC:    carry_nxt = carry_r | i_bit_value;
                            OP_ORNC:   carry_nxt = carry_r | ~i_bit_value;
                            OP_LONG_JUMP:   pc_nxt = {i_byte2, i_byte3};
                            OP_LONG_CALL: begin
                                pc_nxt   = {i_byte2, i_byte3};
                                push_nxt = 1'b1;
                            end
                            OP_SHORT_JUMP:   pc_nxt = rel_target(next_pc, i_byte2);
                            OP_JMPI:   pc_nxt = i_data_pointer_16 + {8'h00, i_acc};
                            OP_JZ: if (i_acc == 8'h00)
                                pc_nxt = rel_target(next_pc, i_byte2);
                            OP_JNZ: if (i_acc != 8'h00)
                                pc_nxt = rel_target(next_pc, i_byte2);
                            OP_JC: if (carry_r)
                                pc_nxt = rel_target(next_pc, i_byte2);
                            OP_JNC: if (!carry_r)
                                pc_nxt = rel_target(next_pc, i_byte2);
                            OP_JB: if (i_bit_value)
                                pc_nxt = rel_target(next_pc, i_byte3);
                            OP_JNB: if (!i_bit_value)
                                pc_nxt = rel_target(next_pc, i_byte3);
                            OP_JBC: if (i_bit_value) begin
                                pc_nxt     = rel_target(next_pc, i_byte3);
                                bit_we_nxt = 1'b1;
                                bit_wd_nxt = 1'b0;
                            end
                            OP_CJAI: if (i_acc != i_byte2)
                                pc_nxt = rel_target(next_pc, i_byte3);
                            OP_CJAD: if (i_acc != i_operand)
                                pc_nxt = rel_target(next_pc, i_byte3);
                            8'hB6, 8'hB7: if (i_indirect_data != i_byte2)
                                pc_nxt = rel_target(next_pc, i_byte3);
                            OP_DJD: begin
                                byte_we_nxt = 1'b1;
                                byte_wd_nxt = dec_val;
                                if (dec_val != 8'h00)
                                    pc_nxt = rel_target(next_pc, i_byte3);
                            end
                            OP_RET, OP_INTERRUPT_EXIT: begin
                                pc_nxt  = i_stack_pc;
                                pop_nxt = 1'b1;
                                rel_nxt = (i_opcode == OP_INTERRUPT_EXIT);
                            end
                            default: pc_nxt = next_pc;
                        endcase
                    end
                    if (cyc_w == CYC_2) begin
                        state_nxt = BBD_EXEC;
                    end else begin
                        done_nxt = 1'b1;
                    end
                end
            end
            BBD_EXEC: begin
                done_nxt  = 1'b1;
                state_nxt = BBD_FETCH;
            end
            default: state_nxt = BBD_FETCH;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r    <= BBD_FETCH;
            pc_r       <= PC_RESET;
            carry_r    <= 1'b0;
            done_r     <= 1'b0;
            ill_r      <= 1'b0;
            bit_addr_r <= 8'h00;
            bit_we_r   <= 1'b0;
            bit_wd_r   <= 1'b0;
            byte_we_r  <= 1'b0;
            byte_wd_r  <= 8'h00;
            push_r     <= 1'b0;
            pop_r      <= 1'b0;
            rel_r      <= 1'b0;
            len_r      <= 2'd0;
        end else begin
            state_r    <= state_nxt;
            pc_r       <= pc_nxt;
            carry_r    <= carry_nxt;
            done_r     <= done_nxt;
            ill_r      <= ill_nxt;
            bit_addr_r <= bit_addr_nxt;
            bit_we_r   <= bit_we_nxt;
            bit_wd_r   <= bit_wd_nxt;
            byte_we_r  <= byte_we_nxt;
            byte_wd_r  <= byte_wd_nxt;
            push_r     <= push_nxt;
            pop_r      <= pop_nxt;
            rel_r      <= rel_nxt;
            len_r      <= len_nxt;
        end
    end

    assign o_done         = done_r;
    assign o_illegal      = ill_r;
    assign o_pc           = pc_r;
    assign o_carry        = carry_r;
    assign o_bit_addr     = bit_addr_r;
    assign o_bit_we       = bit_we_r;
    assign o_bit_wdata    = bit_wd_r;
    assign o_byte_we      = byte_we_r;
    assign o_byte_wdata   = byte_wd_r;
    assign o_push_pc      = push_r;
    assign o_pop_pc       = pop_r;
    assign o_release_prio = rel_r;
    assign o_len          = len_r;

    AST_CARRY_ONE_CYCLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_SETBC) |=> (o_done && o_carry))
        else $error("carry set did not finish in one cycle");
    AST_CLR_CARRY: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_CLRC) |=> (!o_carry && o_len == 2'd1))
        else $error("carry clear wrong");
    AST_AND_TWO_CYCLES: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_ANC) |=> !o_done ##1 o_done)
        else $error("bit and to carry not two cycles");
    AST_OR_RESULT: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_ORNC && !i_bit_value) |=> o_carry)
        else $error("or complement into carry wrong");
    AST_MOV_BIT_CARRY: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_MOVBC)
        |=> (o_bit_we && o_bit_wdata == $past(carry_r) && !o_done) ##1 o_done)
        else $error("carry to bit wrong");
    AST_LONG_JUMP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_LONG_JUMP)
        |=> (o_pc == {$past(i_byte2), $past(i_byte3)} && o_len == 2'd3))
        else $error("long jump target wrong");
    AST_PAGE_JUMP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode[4:0] == 5'h01)
        |=> (o_pc[10:0] == {$past(i_opcode[7:5]), $past(i_byte2)} && !o_push_pc))
        else $error("page jump target wrong");
    AST_SHORT_JUMP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_SHORT_JUMP)
        |=> o_pc == $past(i_pc) + 16'd2 + {{8{$past(i_byte2[7])}}, $past(i_byte2)})
        else $error("short jump target wrong");
    AST_JZ_FALL: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_JZ && i_acc != 8'h00)
        |=> o_pc == $past(i_pc) + 16'd2)
        else $error("accumulator zero branch taken wrongly");
    AST_JBC_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == BBD_FETCH && i_start && i_opcode == OP_JBC && i_bit_value)
        |=> (o_bit_we && !o_bit_wdata))
        else $error("test and clear did not clear bit");
endmodule

// >>> hdl/bbd_len_table.sv
// Instruction length and cycle count lookup for the decoder.
// Assumes the opcode is valid for the whole cycle in which it is read.
`timescale 1ns/1ps
module bbd_len_table (
    input  wire logic [7:0] i_opcode,
    output logic      [1:0] o_len,
    output logic      [1:0] o_cycles,
    output logic            o_known
);
    import bbd_pkg::*;

    always_comb begin
        o_len    = LEN_1;
        o_cycles = CYC_1;
        o_known  = 1'b1;
        if (i_opcode[3:0] == LO_PAGE) begin
            o_len    = LEN_2;
            o_cycles = CYC_2;
        end else if (i_opcode[7:4] == HI_COMPARE_BRANCH_UNEQUAL && i_opcode[3]) begin
            o_len    = LEN_3;
            o_cycles = CYC_2;
        end else if (i_opcode[7:4] == HI_DECREMENT_BRANCH_NONZERO && i_opcode[3]) begin
            o_len    = LEN_2;
            o_cycles = CYC_2;
        end else begin
            case (i_opcode)
                OP_CLRC, OP_SETBC, OP_CPLC, OP_NOP: begin
                    o_len    = LEN_1;
                    o_cycles = CYC_1;
                end
                OP_CLRB, OP_SETBB, OP_CPLB, OP_MOVCB: begin
                    o_len    = LEN_2;
                    o_cycles = CYC_1;
                end
                OP_ANC, OP_ANNC, OP_ORC, OP_ORNC, OP_MOVBC, OP_SHORT_JUMP,
                OP_JZ, OP_JNZ, OP_JC, OP_JNC: begin
                    o_len    = LEN_2;
                    o_cycles = CYC_2;
                end
                OP_LONG_JUMP, OP_LONG_CALL, OP_JB, OP_JNB, OP_JBC,
                OP_CJAI, OP_CJAD, 8'hB6, 8'hB7, OP_DJD: begin
                    o_len    = LEN_3;
                    o_cycles = CYC_2;
                end
                OP_RET, OP_INTERRUPT_EXIT, OP_JMPI: begin
                    o_len    = LEN_1;
                    o_cycles = CYC_2;
                end
                default: begin
                    o_known = 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> include/bbd_pkg.sv
// Constants, opcodes and timing for the bit and branch decoder.
// Assumes a single 20 MHz machine-cycle clock shared with the core.
package bbd_pkg;
    localparam logic [7:0] OP_NOP      = 8'h00;
    localparam logic [7:0] OP_LONG_JUMP     = 8'h02;
    localparam logic [7:0] OP_JBC      = 8'h10;
    localparam logic [7:0] OP_LONG_CALL    = 8'h12;
    localparam logic [7:0] OP_JB       = 8'h20;
    localparam logic [7:0] OP_RET      = 8'h22;
    localparam logic [7:0] OP_JNB      = 8'h30;
    localparam logic [7:0] OP_INTERRUPT_EXIT     = 8'h32;
    localparam logic [7:0] OP_JC       = 8'h40;
    localparam logic [7:0] OP_JNC      = 8'h50;
    localparam logic [7:0] OP_JZ       = 8'h60;
    localparam logic [7:0] OP_JNZ      = 8'h70;
    localparam logic [7:0] OP_ORC      = 8'h72;
    localparam logic [7:0] OP_JMPI     = 8'h73;
    localparam logic [7:0] OP_SHORT_JUMP     = 8'h80;
    localparam logic [7:0] OP_ANC      = 8'h82;
    localparam logic [7:0] OP_MOVBC    = 8'h92;
    localparam logic [7:0] OP_ORNC     = 8'hA0;
    localparam logic [7:0] OP_MOVCB    = 8'hA2;
    localparam logic [7:0] OP_ANNC     = 8'hB0;
    localparam logic [7:0] OP_CPLB     = 8'hB2;
    localparam logic [7:0] OP_CPLC     = 8'hB3;
    localparam logic [7:0] OP_CJAI     = 8'hB4;
    localparam logic [7:0] OP_CJAD     = 8'hB5;
    localparam logic [7:0] OP_CLRB     = 8'hC2;
    localparam logic [7:0] OP_CLRC     = 8'hC3;
    localparam logic [7:0] OP_SETBB    = 8'hD2;
    localparam logic [7:0] OP_SETBC    = 8'hD3;
    localparam logic [7:0] OP_DJD      = 8'hD5;
    localparam logic [3:0] HI_COMPARE_BRANCH_UNEQUAL     = 4'hB;
    localparam logic [3:0] HI_DECREMENT_BRANCH_NONZERO     = 4'hD;
    localparam logic [3:0] LO_PAGE     = 4'h1;
    localparam logic [7:0] DIRECT_RAM_TOP = 8'h7F;
    localparam logic [2:0] BIT_IN_BYTE_W  = 3'd3;
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam logic [1:0] LEN_1       = 2'd1;
    localparam logic [1:0] LEN_2       = 2'd2;
    localparam logic [1:0] LEN_3       = 2'd3;
    localparam logic [1:0] CYC_1       = 2'd1;
    localparam logic [1:0] CYC_2       = 2'd2;
    typedef enum logic [1:0] {
        BBD_FETCH = 2'b00,
        BBD_EXEC  = 2'b01,
        BBD_DONE  = 2'b10
    } bbd_state_t;
endpackage
